// ### hdl/fcs_pkg.sv
// Package of constants and types for the FIFO channel-select decoder.
`default_nettype none
package fcs_pkg;

  // ==========================================================================
  // Control register field layout
  // ==========================================================================
  localparam int          FCS_SEL_MSB   = 6;       // Upper bit of the selection field.
  localparam int          FCS_SEL_LSB   = 3;       // Lower bit of the selection field.
  localparam logic [7:0]  FCS_CTRL_RST  = 8'h00;   // Reset value of the control byte.

  // ==========================================================================
  // Channel selection codes
  // ==========================================================================
  typedef enum logic [3:0] {
    FCS_XYZ      = 4'b0000,
    FCS_X        = 4'b0001,
    FCS_Y        = 4'b0010,
    FCS_X_DUP    = 4'b0011,
    FCS_XYZ_T    = 4'b0100,
    FCS_X_T      = 4'b0101,
    FCS_Y_T      = 4'b0110,
    FCS_Z_T      = 4'b0111,
    FCS_XYZ_A    = 4'b1000,
    FCS_X_A      = 4'b1001,
    FCS_Y_A      = 4'b1010,
    FCS_Z_A      = 4'b1011
  } fcs_sel_t;

  // Tags that mark each buffered entry with its source.
  typedef enum logic [2:0] {
    FCS_TAG_X    = 3'b000,
    FCS_TAG_Y    = 3'b001,
    FCS_TAG_Z    = 3'b010,
    FCS_TAG_TEMP = 3'b011,
    FCS_TAG_ADC  = 3'b100
  } fcs_tag_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    FCS_IDLE  = 2'b00,
    FCS_EMIT  = 2'b01
  } fcs_state_t;

endpackage : fcs_pkg
`default_nettype wire

// ### hdl/fcs_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module fcs_skid #(
  parameter int W = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [W-1:0]  in_data,
  input  wire logic          in_valid,
  output logic               in_ready,
  output logic [W-1:0]       out_data,
  output logic               out_valid,
  input  wire logic          out_ready
);
  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [W-1:0] mem [2];     // Two entries of storage.
  logic         wr_ptr;      // Write slot.
  logic         rd_ptr;      // Read slot.
  logic [1:0]   count;       // Entries held.
  logic         push;        // Write accepted.
  logic         pop;         // Read accepted.

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];

  // Entry storage is written on each accepted word.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and occupancy move with push and pop.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Occupancy never exceeds two entries.
  count_bound_a: assert property (@(posedge clk) disable iff (rst) count <= 2'd2)
    else $error("buffer occupancy above two");
endmodule : fcs_skid
`default_nettype wire

// ### hdl/fcs_decoder.sv
// Channel-select decoder that orders sample-set entries into a buffer.
//
// Summary of operation
// - Selection field bits 6:3, read/write, resets zero.
// - 0000 buffers x,y,z; 0001 buffers x only.
// - 0010 buffers y only, plus enabled extras.
// - 0011 converts x only, as printed.
// - 0100 buffers x,y,z plus temperature.
// - 0101-0111 buffer one axis plus temperature.
// - 1000 buffers x,y,z plus auxiliary input.
// - 1001-1011 buffer one axis plus auxiliary.
`timescale 1ns/1ps
`default_nettype none
module fcs_decoder
  import fcs_pkg::*;
#(
  parameter int DW = 14
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ctrl_we,
  input  wire logic [7:0]    ctrl_wdata,
  output logic [7:0]         ctrl_rdata,
  input  wire logic          temp_en,
  input  wire logic          adc_en,
  input  wire logic          odr_tick,
  input  wire logic [DW-1:0] x_data,
  input  wire logic [DW-1:0] y_data,
  input  wire logic [DW-1:0] z_data,
  input  wire logic [DW-1:0] temp_data,
  input  wire logic [DW-1:0] adc_data,
  output logic [DW+2:0]      out_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic               set_busy,
  output logic               tick_lost
);
  import fcs_pkg::*;

  // ==========================================================================
  // Control register
  // ==========================================================================
  logic [7:0]    ctrl;           // Whole control byte, selection field inside.
  logic [3:0]    sel;            // Selection field.
  logic [4:0]    mask;           // Sources enabled: bit0 x, 1 y, 2 z, 3 temp, 4 adc.
  logic [4:0]    pend;           // Sources still to emit in the current set.
  logic [DW-1:0] snap [5];       // Samples captured at the tick.
  fcs_state_t    state;          // Sequencer state.
  logic [2:0]    cur;            // Index of the source being emitted.
  logic [DW+2:0] buf_in;         // Tagged word toward the buffer.
  logic          buf_ready;      // Buffer can take a word.
  logic          emit;           // Word accepted into the buffer this cycle.

  assign sel = ctrl[FCS_SEL_MSB:FCS_SEL_LSB];

  // The whole byte is stored so the host reads back what it wrote.
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl <= FCS_CTRL_RST;
    else if (ctrl_we)
      ctrl <= ctrl_wdata;
  end

  // Readback comes from a flip-flop.
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_rdata <= FCS_CTRL_RST;
    else
      ctrl_rdata <= ctrl;
  end

  // ==========================================================================
  // Code decode
  // ==========================================================================
  // Extras only enter when their converter is enabled; prohibited codes buffer nothing.
  always_comb
  begin
    mask = 5'h00;
    unique case (sel)
      FCS_XYZ:   mask = 5'h07;
      FCS_X:     mask = 5'h01;
      FCS_Y:     mask = {adc_en, temp_en, 3'b010};
      FCS_X_DUP: mask = 5'h01;
      FCS_XYZ_T: mask = {1'b0, temp_en, 3'b111};
      FCS_X_T:   mask = {1'b0, temp_en, 3'b001};
      FCS_Y_T:   mask = {1'b0, temp_en, 3'b010};
      FCS_Z_T:   mask = {1'b0, temp_en, 3'b100};
      FCS_XYZ_A: mask = {adc_en, 4'b0111};
      FCS_X_A:   mask = {adc_en, 4'b0001};
      FCS_Y_A:   mask = {adc_en, 4'b0010};
      FCS_Z_A:   mask = {adc_en, 4'b0100};
      default:   mask = 5'h00;
    endcase
  end

  // ==========================================================================
  // Sample-set sequencer
  // ==========================================================================
  // The lowest pending index goes first, giving x, y, z, then temp, then adc.
  always_comb
  begin
    cur = 3'd0;
    for (int i = 4; i >= 0; i--)
      if (pend[i])
        cur = 3'(i);
  end

  assign buf_in = {cur, snap[cur]};
  assign emit   = (state == FCS_EMIT) && buf_ready;

  // Samples are frozen at the tick so a set is coherent.
  always_ff @(posedge clk)
  begin
    if (state == FCS_IDLE && odr_tick)
    begin
      snap[0] <= x_data;
      snap[1] <= y_data;
      snap[2] <= z_data;
      snap[3] <= temp_data;
      snap[4] <= adc_data;
    end
  end

  // Pending mask walks down as the buffer accepts each word.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= FCS_IDLE;
      pend  <= 5'h00;
    end
    else
    begin
      unique case (state)
        FCS_IDLE:
        begin
          if (odr_tick && mask != 5'h00)
          begin
            pend  <= mask;
            state <= FCS_EMIT;
          end
        end
        FCS_EMIT:
        begin
          if (emit)
          begin
            pend[cur] <= 1'b0;
            if ((pend & ~(5'h01 << cur)) == 5'h00)
              state <= FCS_IDLE;
          end
        end
        default: state <= FCS_IDLE;
      endcase
    end
  end

  // Status flags from flip-flops: busy, and a tick missed while busy.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      set_busy  <= 1'b0;
      tick_lost <= 1'b0;
    end
    else
    begin
      set_busy  <= (state == FCS_EMIT) || (odr_tick && mask != 5'h00);
      tick_lost <= odr_tick && (state == FCS_EMIT);
    end
  end

  // ==========================================================================
  // Output buffer and registered outputs
  // ==========================================================================
  logic [DW+2:0] sk_data;        // Buffer head word.
  logic          sk_valid;       // Buffer head valid.
  logic          sk_pop;         // Head moved to output stage.

  fcs_skid #(.W(DW + 3)) u_skid (
    .clk       (clk),
    .rst       (rst),
    .in_data   (buf_in),
    .in_valid  (state == FCS_EMIT),
    .in_ready  (buf_ready),
    .out_data  (sk_data),
    .out_valid (sk_valid),
    .out_ready (sk_pop)
  );

  assign sk_pop = sk_valid && (!out_valid || out_ready);

  // Output stage register keeps outputs straight from flip-flops.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (!out_valid || out_ready)
    begin
      out_valid <= sk_valid;
      if (sk_valid)
        out_data <= sk_data;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence set_start_s;
    state == FCS_IDLE && odr_tick && sel == FCS_XYZ;
  endsequence

  // Reset clears the field and its readback at the next edge.
  sel_reset_a: assert property (@(posedge clk) rst |=> sel == 4'h0 && ctrl_rdata == FCS_CTRL_RST)
    else $error("selection not cleared by reset");
  // A write lands in the field at the next edge and in the readback one edge after that.
  sel_write_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_we |=> sel == $past(ctrl_wdata[FCS_SEL_MSB:FCS_SEL_LSB]) ##1 ctrl_rdata == $past(ctrl_wdata, 2))
    else $error("selection field not written");
  xyz_set_a: assert property (@(posedge clk) disable iff (rst)
    set_start_s |=> pend == 5'h07)
    else $error("xyz set not loaded");
  y_only_a: assert property (@(posedge clk) disable iff (rst)
    sel == FCS_Y |-> mask[2:0] == 3'b010)
    else $error("y code decodes wrongly");
  dup_x_a: assert property (@(posedge clk) disable iff (rst)
    sel == FCS_X_DUP |-> mask == 5'h01)
    else $error("0011 not x only");
  temp_gate_a: assert property (@(posedge clk) disable iff (rst)
    sel == FCS_XYZ_T |-> mask == {1'b0, temp_en, 3'b111})
    else $error("temperature set decodes wrongly");
  one_temp_a: assert property (@(posedge clk) disable iff (rst)
    (sel >= FCS_X_T && sel <= FCS_Z_T) |-> $onehot(mask[2:0]) && !mask[4])
    else $error("single axis temperature code wrong");
  adc_gate_a: assert property (@(posedge clk) disable iff (rst)
    (sel[3:2] == 2'b10) |-> mask[4] == adc_en && !mask[3])
    else $error("auxiliary code decodes wrongly");
  bad_code_a: assert property (@(posedge clk) disable iff (rst)
    sel[3:2] == 2'b11 |-> mask == 5'h00)
    else $error("prohibited code buffers data");
  order_a: assert property (@(posedge clk) disable iff (rst)
    emit ##1 (state == FCS_EMIT && emit) |-> cur > $past(cur))
    else $error("set entries out of order");
endmodule : fcs_decoder
`default_nettype wire

// ### verif/fcs_host_model.sv
// Host-side model that drains the decoder output and may stall it.
`timescale 1ns/1ps
`default_nettype none
module fcs_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  output logic      out_ready
);
  // ==========================================================================
  // Readiness pattern
  // ==========================================================================
  logic [7:0] seq;  // Private shift register for the stall pattern.

  // Ready moves at the falling edge so the decoder sees a settled level.
  always @(negedge clk)
  begin
    if (rst)
    begin
      seq       <= 8'h5A;
      out_ready <= 1'b0;
    end
    else
    begin
      seq       <= {seq[6:0], seq[7] ^ seq[5] ^ seq[4] ^ seq[3]};
      out_ready <= slow ? seq[0] : 1'b1;  // A slow host stalls about half the time.
    end
  end
endmodule : fcs_host_model
`default_nettype wire

// ### verif/test_fcs_channel_select_decoder.sv
// Self-checking testbench of the channel-select decoder.
`timescale 1ns/1ps
`default_nettype none
module test_fcs_channel_select_decoder;
  import fcs_pkg::*;
  localparam int DW = 14;
  logic          clk = 0, rst = 1, ctrl_we = 0, temp_en = 0, adc_en = 0;
  logic          odr_tick = 0, slow = 0, out_valid, out_ready, set_busy, tick_lost;
  logic [7:0]    ctrl_wdata = 8'h00, ctrl_rdata, st = 8'h1D;
  logic [DW-1:0] x_data = 0, y_data = 0, z_data = 0, temp_data = 0, adc_data = 0;
  logic [DW+2:0] out_data;
  logic [DW+2:0] got[$];  // Words taken by the host.
  int            n_fail = 0, checked = 0, cycles = 0;

  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;

  fcs_decoder #(.DW(DW)) dut (.clk(clk), .rst(rst), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .ctrl_rdata(ctrl_rdata), .temp_en(temp_en), .adc_en(adc_en), .odr_tick(odr_tick),
    .x_data(x_data), .y_data(y_data), .z_data(z_data), .temp_data(temp_data), .adc_data(adc_data),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .set_busy(set_busy),
    .tick_lost(tick_lost));
  fcs_host_model host (.clk(clk), .rst(rst), .slow(slow), .out_ready(out_ready));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Next value of the stimulus shift register.
  function automatic logic [7:0] rnd();
    st = {st[6:0], st[7] ^ st[5] ^ st[4] ^ st[3]};
    return st;
  endfunction : rnd

  // Sources a code buffers: bits are x, y, z, temperature, auxiliary.
  function automatic logic [4:0] exp_mask(input logic [3:0] c, input logic te, input logic ae);
    logic [2:0] ax;
    ax = (c[1:0] == 2'h0) ? 3'h7 : (c[1:0] == 2'h1) ? 3'h1 : (c[1:0] == 2'h2) ? 3'h2 :
         (c[3:2] == 2'h0) ? 3'h1 : 3'h4;
    case (c[3:2])
      2'h0: return {(c[1:0] == 2'h2) & ae, (c[1:0] == 2'h2) & te, ax};
      2'h1: return {1'b0, te, ax};
      2'h2: return {ae, 1'b0, ax};
      default: return 5'h00;  // Forbidden codes emit nothing.
    endcase
  endfunction : exp_mask

  // Records a mismatch.
  task automatic fail(input string msg);
    n_fail++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Words accepted by the host are collected at the rising edge.
  always @(posedge clk)
  begin
    cycles++;
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back(out_data);
    if (cycles == 60000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Programs a code, fires a set and a dropped second tick, then checks the words.
  task automatic run_set(input logic [3:0] code, input logic te, input logic ae, input logic sl);
    logic [4:0]    m;
    logic [DW-1:0] s[5];
    logic [DW+2:0] exp[$];
    logic          lost;
    int            w;
    m = exp_mask(code, te, ae);
    @(negedge clk);
    ctrl_we    = 1;
    ctrl_wdata = {rnd() & 8'h87} | {1'b0, code, 3'h0};
    temp_en    = te;
    adc_en     = ae;
    slow       = sl;
    @(negedge clk);
    ctrl_we = 0;
    repeat (2) @(negedge clk);
    checked++; if (ctrl_rdata !== ctrl_wdata) fail("control readback");
    for (int i = 0; i < 5; i++)
    begin
      s[i] = DW'({rnd(), rnd()});
      if (m[i])
        exp.push_back({i[2:0], s[i]});
    end
    {x_data, y_data, z_data, temp_data, adc_data} = {s[0], s[1], s[2], s[3], s[4]};
    got.delete();
    odr_tick = 1;
    @(negedge clk);
    x_data = ~x_data;  // The second tick lands while busy and must be dropped.
    @(negedge clk);
    odr_tick = 0;
    // The dropped-tick pulse stands only from the last rising edge to the next, so take it now.
    lost     = (tick_lost === 1'b1);
    w        = 0;
    checked++; if (set_busy !== (m != 5'h00)) fail("busy flag");
    while ((got.size() < exp.size() || set_busy !== 1'b0) && w < 300)
    begin
      @(negedge clk);
      lost = lost | (tick_lost === 1'b1);
      w++;
    end
    repeat (8) @(negedge clk);
    checked++; if (got.size() != exp.size()) fail("word count");
    foreach (exp[i])
    begin
      checked++; if (i >= got.size() || got[i] !== exp[i]) fail("word order or value");
    end
    checked++; if (lost !== (m != 5'h00)) fail("dropped tick flag");
  endtask : run_set

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 0;
    @(negedge clk);
    checked++; if (ctrl_rdata !== 8'h00 || out_valid !== 1'b0 || out_data !== '0) fail("reset state");
    checked++; if (set_busy !== 1'b0 || tick_lost !== 1'b0) fail("reset flags");
    for (int c = 0; c < 16; c++)
      run_set(c[3:0], 1'b1, 1'b1, 1'b0);
    for (int c = 0; c < 12; c++)
      run_set(c[3:0], 1'b0, 1'b0, 1'b1);
    for (int t = 0; t < 40; t++)
      run_set(4'(rnd() % 12), rnd() > 8'h7F, rnd() > 8'h7F, rnd() > 8'h7F);
    tally_and_finish();
  end
endmodule : test_fcs_channel_select_decoder
`default_nettype wire
